//--- diag_ctrl.sv
// module: bridge behaviour and diagnostic control bytes at configuration dword 0x40
`timescale 1ns/1ns
module diag_ctrl #(
    parameter int CHIP_RST_CYCLES = diag_ctrl_pkg::CHIP_RST_CYCLES
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // configuration access
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_primary_cmd_byte_enable_n,
    input  wire logic [31:0] i_cfg_wdata,
    output logic [31:0]      o_cfg_rdata,
    output logic             o_cfg_rvalid,
    // memory write target
    input  wire logic        i_mw_data_xfer,
    input  wire logic        i_mw_queue_full,
    input  wire logic [11:2] i_mw_addr,
    input  wire logic [7:0]  i_cache_line_dw,
    output logic             o_mw_disconnect,
    // upstream memory read
    input  wire logic        i_ur_start,
    input  wire logic [3:0]  i_ur_cmd,
    input  wire logic [3:0]  i_ur_be_n,
    output logic             o_ur_prefetch,
    output logic             o_ur_single_dword,
    output logic             o_ur_disconnect_first,
    output logic [3:0]       o_ur_fwd_be_n,
    // live insertion
    input  wire logic        i_insert_sense,
    input  wire logic        i_sense_input_only,
    input  wire logic        i_cmd_io_en,
    input  wire logic        i_cmd_mem_en,
    input  wire logic        i_cmd_master_en,
    output logic             o_io_en,
    output logic             o_mem_en,
    output logic             o_master_en,
    output logic             o_refuse_io_mem,
    // resets
    input  wire logic        i_bctl_sec_reset,
    output logic             o_bctl_sec_reset_set,
    output logic             o_sec_rst_n,
    output logic             o_sec_if_reset,
    output logic             o_chip_rst_active,
    output logic             o_cfg_regs_clear,
    // counter test
    output logic [2:0]       o_cnt_byte_en
);

    localparam int              RST_CW = diag_ctrl_pkg::CHIP_RST_CW;
    diag_ctrl_pkg::diag_state_s q;
    diag_ctrl_pkg::diag_state_s d;
    logic                       hit;
    logic                       wr_bhv;
    logic                       wr_diag;
    logic                       b4k;
    logic                       bcl;
    logic                       plain_rd;
    logic [31:0]                rd_word;
    logic [31:0]                lane_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // decoders

    // 00 all bytes, 01 byte 1, 10 byte 2, 11 byte 0
    function automatic logic [2:0] test_decode(input logic [1:0] mode);
        case (mode)
            diag_ctrl_pkg::TEST_NORMAL: test_decode = 3'h7;
            diag_ctrl_pkg::TEST_BYTE1:  test_decode = 3'h2;
            diag_ctrl_pkg::TEST_BYTE2:  test_decode = 3'h4;
            diag_ctrl_pkg::TEST_BYTE0:  test_decode = 3'h1;
            default:                    test_decode = 3'h7;
        endcase
    endfunction

    // line size must be a power of two; zero means no cache line disconnects
    function automatic logic line_end(input logic [7:0] dw, input logic [7:0] size);
        line_end = (size != 8'h00) && ((dw & (size - 8'h01)) == (size - 8'h01));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d          = q;
        d.rvalid   = 1'b0;
        d.cfg_clear = 1'b0;
        d.sec_set  = 1'b0;
        hit        = (i_cfg_addr[7:2] == diag_ctrl_pkg::CHIP_CTRL_OFF[7:2]);
        // writes are dropped while the chip reset sequence runs
        wr_bhv     = i_cfg_wr & hit & ~i_primary_cmd_byte_enable_n[diag_ctrl_pkg::BHV_LANE]
                     & (q.st == diag_ctrl_pkg::CR_IDLE);
        wr_diag    = i_cfg_wr & hit & ~i_primary_cmd_byte_enable_n[diag_ctrl_pkg::DIAG_LANE]
                     & (q.st == diag_ctrl_pkg::CR_IDLE);

        if (wr_bhv) begin
            // only the three defined bits take a value
            d.wdc    = i_cfg_wdata[diag_ctrl_pkg::WDC_BIT];
            d.pf_dis = i_cfg_wdata[diag_ctrl_pkg::PF_DIS_BIT];
            d.live   = i_cfg_wdata[diag_ctrl_pkg::LIVE_BIT];
        end
        if (wr_diag) begin
            d.test_mode = i_cfg_wdata[diag_ctrl_pkg::TEST_LSB +: 2];
        end

        case (q.st)
            diag_ctrl_pkg::CR_IDLE: begin
                // a zero in the reset bit leaves the sequencer alone
                if (wr_diag && i_cfg_wdata[diag_ctrl_pkg::CHIP_RST_BIT]) begin
                    d.st        = diag_ctrl_pkg::CR_BUSY;
                    d.rst_cnt   = RST_CW'(CHIP_RST_CYCLES - 1);
                    d.sec_set   = 1'b1;
                    d.wdc       = diag_ctrl_pkg::BHV_RESET[diag_ctrl_pkg::WDC_BIT];
                    d.pf_dis    = diag_ctrl_pkg::BHV_RESET[diag_ctrl_pkg::PF_DIS_BIT];
                    d.live      = diag_ctrl_pkg::BHV_RESET[diag_ctrl_pkg::LIVE_BIT];
                    d.test_mode = diag_ctrl_pkg::DIAG_RESET[1:0];
                end
            end
            diag_ctrl_pkg::CR_BUSY: begin
                if (q.rst_cnt == '0) begin
                    d.st        = diag_ctrl_pkg::CR_IDLE;
                    d.cfg_clear = 1'b1;
                end else begin
                    d.rst_cnt = q.rst_cnt - RST_CW'(1);
                end
            end
            default: begin
                d.st = diag_ctrl_pkg::CR_IDLE;
            end
        endcase

        // configuration read, lanes not enabled read zero
        rd_word   = '0;
        rd_word[diag_ctrl_pkg::WDC_BIT]      = q.wdc;
        rd_word[diag_ctrl_pkg::PF_DIS_BIT]   = q.pf_dis;
        rd_word[diag_ctrl_pkg::LIVE_BIT]     = q.live;
        rd_word[diag_ctrl_pkg::CHIP_RST_BIT] = (q.st == diag_ctrl_pkg::CR_BUSY);
        rd_word[diag_ctrl_pkg::TEST_LSB +: 2] = q.test_mode;
        lane_mask = {{8{~i_primary_cmd_byte_enable_n[3]}}, {8{~i_primary_cmd_byte_enable_n[2]}},
                     {8{~i_primary_cmd_byte_enable_n[1]}}, {8{~i_primary_cmd_byte_enable_n[0]}}};
        if (i_cfg_rd) begin
            d.rvalid = 1'b1;
            d.rdata  = hit ? (rd_word & lane_mask) : '0;
        end

        // memory write disconnect points
        b4k       = (i_mw_addr == diag_ctrl_pkg::DW_4K_LAST);
        bcl       = line_end(i_mw_addr[9:2], i_cache_line_dw);
        d.mw_disc = i_mw_data_xfer & (i_mw_queue_full | b4k | (q.wdc & bcl));

        // upstream read handling, latched per transaction
        plain_rd = (i_ur_cmd == diag_ctrl_pkg::CMD_MEM_READ);
        if (i_ur_start) begin
            d.ur_single     = q.pf_dis & plain_rd;
            d.ur_prefetch   = ~(q.pf_dis & plain_rd);
            d.ur_disc_first = q.pf_dis & plain_rd;
            // with prefetch the bridge reads whole dwords
            d.ur_be_n       = (q.pf_dis & plain_rd) ? i_ur_be_n : 4'h0;
        end

        // secondary reset follows the control bit, held up by a running chip reset
        d.chip_rst_active = (d.st == diag_ctrl_pkg::CR_BUSY);
        d.sec_rst_n = ~(i_bctl_sec_reset | d.sec_set | d.chip_rst_active);
        d.sec_if_reset    = ~d.sec_rst_n;
        d.cnt_byte_en     = test_decode(d.test_mode);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            q <= diag_ctrl_pkg::DIAG_STATE_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // live insertion masking
    insertion_mask u_insertion_mask (
        .i_clk_sys          (i_clk_sys),
        .i_rstn             (i_rstn),
        .i_live_mode        (q.live),
        .i_sense_input_only (i_sense_input_only),
        .i_insert_sense     (i_insert_sense),
        .i_cmd_io_en        (i_cmd_io_en),
        .i_cmd_mem_en       (i_cmd_mem_en),
        .i_cmd_master_en    (i_cmd_master_en),
        .o_io_en            (o_io_en),
        .o_mem_en           (o_mem_en),
        .o_master_en        (o_master_en),
        .o_refuse_io_mem    (o_refuse_io_mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_cfg_rdata           = q.rdata;
    assign o_cfg_rvalid          = q.rvalid;
    assign o_mw_disconnect       = q.mw_disc;
    assign o_ur_prefetch         = q.ur_prefetch;
    assign o_ur_single_dword     = q.ur_single;
    assign o_ur_disconnect_first = q.ur_disc_first;
    assign o_ur_fwd_be_n         = q.ur_be_n;
    assign o_bctl_sec_reset_set  = q.sec_set;
    assign o_sec_rst_n           = q.sec_rst_n;
    assign o_sec_if_reset        = q.sec_if_reset;
    assign o_chip_rst_active     = q.chip_rst_active;
    assign o_cfg_regs_clear      = q.cfg_clear;
    assign o_cnt_byte_en         = q.cnt_byte_en;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    rsvd_read_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_cfg_rvalid |-> ((o_cfg_rdata & 32'hFFFF_F8CD) == 32'h0000_0000))
        else $error("reserved bit read nonzero");
    // a chip reset start clears lane 0 on purpose, so it is left out here
    lane_skip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_cfg_wr && hit && i_primary_cmd_byte_enable_n[0]
        && !(wr_diag && i_cfg_wdata[diag_ctrl_pkg::CHIP_RST_BIT])
        |=> $stable(q.wdc) && $stable(q.live))
        else $error("lane 0 written without its enable");
    zero_no_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (q.st == diag_ctrl_pkg::CR_IDLE) && wr_diag && !i_cfg_wdata[diag_ctrl_pkg::CHIP_RST_BIT]
        |=> !o_chip_rst_active)
        else $error("chip reset started by a zero");
    rst_seq_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $fell(o_chip_rst_active) |-> $past(o_chip_rst_active, CHIP_RST_CYCLES)
        && !$past(o_chip_rst_active, CHIP_RST_CYCLES + 1))
        else $error("chip reset shorter than expected");
    self_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $fell(o_chip_rst_active) |-> o_cfg_regs_clear && !q.wdc && (q.test_mode == 2'h0))
        else $error("chip reset end without clear");
    sec_with_chip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_chip_rst_active) |-> o_bctl_sec_reset_set && !o_sec_rst_n)
        else $error("secondary reset not raised by chip reset");
    sec_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $past(i_rstn) && !o_chip_rst_active && !o_bctl_sec_reset_set
        |-> (o_sec_rst_n == !$past(i_bctl_sec_reset)))
        else $error("secondary reset not following bit");
    wdc_cl_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_mw_data_xfer && !i_mw_queue_full && !b4k && bcl |=> (o_mw_disconnect == $past(q.wdc)))
        else $error("cache line disconnect wrong");
    pf_line_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_ur_start && !plain_rd |=> o_ur_prefetch && !o_ur_disconnect_first)
        else $error("line read lost prefetch");
    pf_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_ur_start && plain_rd && q.pf_dis
        |=> o_ur_single_dword && o_ur_disconnect_first && (o_ur_fwd_be_n == $past(i_ur_be_n)))
        else $error("single dword read handling wrong");
    test_sel_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (q.test_mode == 2'h3) |-> (o_cnt_byte_en == 3'h1))
        else $error("test mode decode wrong");
    test_norm_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (q.test_mode == 2'h0) |-> (o_cnt_byte_en == 3'h7))
        else $error("normal mode decode wrong");

    ////////////////////////////////////////////////////////////////////////////////
    // answer timing and further checks; a stale answer would be taken as fresh data by the initiator
    rd_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_cfg_rd |=> o_cfg_rvalid)
        else $error("read not answered");
    rd_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_cfg_rvalid |-> $past(i_cfg_rd))
        else $error("answer without read");
    miss_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_cfg_rd && !hit |=> (o_cfg_rdata == 32'h0000_0000))
        else $error("unmapped read nonzero");
    pf_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_ur_start && !q.pf_dis
        |=> o_ur_prefetch && !o_ur_single_dword && (o_ur_fwd_be_n == 4'h0))
        else $error("prefetching read handling wrong");
    ur_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !i_ur_start |=> $stable(o_ur_fwd_be_n) && $stable(o_ur_prefetch))
        else $error("read handling changed without start");
    clear_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_cfg_regs_clear |=> !o_cfg_regs_clear)
        else $error("clear pulse too long");
    full_disc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_mw_data_xfer && i_mw_queue_full |=> o_mw_disconnect)
        else $error("no disconnect on full queue");
    page_disc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_mw_data_xfer && b4k |=> o_mw_disconnect)
        else $error("no disconnect at page end");
    idle_disc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !i_mw_data_xfer |=> !o_mw_disconnect)
        else $error("disconnect without data phase");
    chip_sec_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_chip_rst_active |-> !o_sec_rst_n && o_sec_if_reset)
        else $error("secondary side free during chip reset");

endmodule // diag_ctrl

//--- diag_ctrl_pkg.sv
// package: offsets, field layout, reset values and state types of the diagnostic control bytes
package diag_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] CHIP_CTRL_OFF     = 8'h40;
    localparam int         BHV_LANE          = 0;
    localparam int         DIAG_LANE         = 1;
    localparam int         WDC_BIT           = 1;
    localparam int         PF_DIS_BIT        = 4;
    localparam int         LIVE_BIT          = 5;
    localparam int         CHIP_RST_BIT      = 8;
    localparam int         TEST_LSB          = 9;
    localparam logic [7:0] BHV_RESET         = 8'h00;
    localparam logic [7:0] DIAG_RESET        = 8'h00;
    localparam logic [1:0] TEST_NORMAL       = 2'h0;
    localparam logic [1:0] TEST_BYTE1        = 2'h1;
    localparam logic [1:0] TEST_BYTE2        = 2'h2;
    localparam logic [1:0] TEST_BYTE0        = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int         CLK_PERIOD_NS     = 100;
    localparam int         CHIP_RST_NS       = 1600;
    localparam int         CHIP_RST_CYCLES   = (CHIP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         CHIP_RST_CW       = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // pci command codes for upstream reads and address boundaries
    localparam logic [3:0] CMD_MEM_READ      = 4'h6;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;
    localparam logic [9:0] DW_4K_LAST        = 10'h3FF;

    ////////////////////////////////////////////////////////////////////////////////
    // state types
    typedef enum logic [0:0] {CR_IDLE, CR_BUSY} chip_rst_e;

    typedef struct packed {
        chip_rst_e              st;
        logic [CHIP_RST_CW-1:0] rst_cnt;
        logic                   wdc;
        logic                   pf_dis;
        logic                   live;
        logic [1:0]             test_mode;
        logic [31:0]            rdata;
        logic                   rvalid;
        logic                   mw_disc;
        logic                   ur_prefetch;
        logic                   ur_single;
        logic                   ur_disc_first;
        logic [3:0]             ur_be_n;
        logic                   sec_rst_n;
        logic                   sec_if_reset;
        logic                   chip_rst_active;
        logic                   cfg_clear;
        logic                   sec_set;
        logic [2:0]             cnt_byte_en;
    } diag_state_s;

    localparam diag_state_s DIAG_STATE_RESET = '{st: CR_IDLE, sec_rst_n: 1'b1,
                                                 cnt_byte_en: 3'h7, ur_be_n: 4'hF,
                                                 default: '0};

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic masked;
        logic io_en;
        logic mem_en;
        logic mst_en;
    } ins_state_s;

endpackage

//--- insertion_mask.sv
// module: insertion-sense synchroniser and masking of the forwarding enables
`timescale 1ns/1ns
module insertion_mask (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    // control
    input  wire logic i_live_mode,
    input  wire logic i_sense_input_only,
    input  wire logic i_insert_sense,
    // stored command enables
    input  wire logic i_cmd_io_en,
    input  wire logic i_cmd_mem_en,
    input  wire logic i_cmd_master_en,
    // effective enables
    output logic      o_io_en,
    output logic      o_mem_en,
    output logic      o_master_en,
    output logic      o_refuse_io_mem
);

    diag_ctrl_pkg::ins_state_s q;
    diag_ctrl_pkg::ins_state_s d;
    logic                      mask;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d       = q;
        d.sync1 = i_insert_sense;
        d.sync2 = q.sync1;
        // level sensitive, so enables come back three cycles after the pin drops
        mask     = i_live_mode & i_sense_input_only & q.sync2;
        d.masked = mask;
        d.io_en  = i_cmd_io_en & ~mask;
        d.mem_en = i_cmd_mem_en & ~mask;
        d.mst_en = i_cmd_master_en & ~mask;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_io_en         = q.io_en;
    assign o_mem_en        = q.mem_en;
    assign o_master_en     = q.mst_en;
    assign o_refuse_io_mem = q.masked;

    ////////////////////////////////////////////////////////////////////////////////
    no_mask_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $past(i_rstn) && !$past(i_live_mode)
        |-> (o_io_en == $past(i_cmd_io_en)) && !o_refuse_io_mem)
        else $error("enable masked while live insertion is off");
    mask_forces_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_refuse_io_mem |-> !o_io_en && !o_mem_en && !o_master_en)
        else $error("enable seen while masked");

endmodule // insertion_mask

//--- cfg_initiator.sv
// partner model: configuration initiator on the primary bus
`timescale 1ns/1ns
module cfg_initiator #(
    parameter int GAP = 0
) (
    // clock
    input  wire logic        i_clk_sys,
    // configuration access
    output logic             o_cfg_wr,
    output logic             o_cfg_rd,
    output logic [7:0]       o_cfg_addr,
    output logic [3:0]       o_be_n,
    output logic [31:0]      o_wdata,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid
);
    initial begin
        o_cfg_wr   = 1'b0;
        o_cfg_rd   = 1'b0;
        o_cfg_addr = 8'h00;
        o_be_n     = 4'hF;
        o_wdata    = 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // idle address, enable and data lines show the inverse and both strobes go low, so a stale value is never mistaken for a valid one
    task automatic idle();
        o_cfg_wr   = 1'b0;
        o_cfg_rd   = 1'b0;
        o_cfg_addr = ~o_cfg_addr;
        o_be_n     = ~o_be_n;
        o_wdata    = ~o_wdata;
        repeat (GAP) @(negedge i_clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge i_clk_sys);
        o_cfg_wr   = 1'b1;
        o_cfg_addr = a;
        o_be_n     = be;
        o_wdata    = d;
        @(negedge i_clk_sys);
        idle();
    endtask

    // answer is registered on the taking edge and read at the next negedge; no answer reads as unknown
    task automatic rd(input logic [7:0] a, input logic [3:0] be, output logic [31:0] q);
        @(negedge i_clk_sys);
        o_cfg_rd   = 1'b1;
        o_cfg_addr = a;
        o_be_n     = be;
        @(negedge i_clk_sys);
        q = (i_rvalid === 1'b1) ? i_rdata : 32'hXXXXXXXX;
        idle();
    endtask
endmodule // cfg_initiator

//--- diag_ctrl_tb.sv
// testbench: diagnostic control bytes and the side controls they drive
`timescale 1ns/1ns
module diag_ctrl_tb;
    typedef struct packed {
        logic [7:0]  addr;
        logic [3:0]  be_w;
        logic [31:0] wdata;
        logic [3:0]  be_r;
        logic [31:0] exp_rd;
        logic [2:0]  exp_cnt;
    } row_s;
    localparam row_s ROWS [7] = '{
        '{8'h40, 4'hE, 32'hFFFFFFFF, 4'h0, 32'h00000032, 3'h7},
        '{8'h40, 4'hD, 32'hFFFFFEFF, 4'h0, 32'h00000632, 3'h1},
        '{8'h40, 4'hD, 32'h00000200, 4'h0, 32'h00000232, 3'h2},
        '{8'h40, 4'hD, 32'h00000400, 4'hE, 32'h00000032, 3'h4},
        '{8'h44, 4'h0, 32'hFFFFFFFF, 4'h0, 32'h00000000, 3'h4},
        '{8'h40, 4'hF, 32'hFFFFFFFF, 4'h0, 32'h00000432, 3'h4},
        '{8'h40, 4'h0, 32'h00000000, 4'h0, 32'h00000000, 3'h7}};
    localparam logic [3:0] CMDS [3] = '{diag_ctrl_pkg::CMD_MEM_READ,
        diag_ctrl_pkg::CMD_MEM_READ_MULT, diag_ctrl_pkg::CMD_MEM_READ_LINE};
    logic        clk_sys, rstn, cfg_wr, cfg_rd, rvalid, mw_xfer, mw_full, mw_disc, ur_start;
    logic [7:0]  cfg_addr, cl_dw;
    logic [3:0]  be_n, ur_cmd, ur_be_n, fwd_be_n;
    logic [31:0] wdata, rdata, q;
    logic [9:0]  mw_addr;
    logic        ur_pre, ur_single, ur_disc, sense, only, io_c, mem_c, mst_c, io, mem, mst;
    logic        refuse, bctl_sec, bctl_set, sec_rst_n, sec_if, chip_act, cfg_clr;
    logic [2:0]  cnt_en;
    int          n_mismatch = 0;
    int          n_checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    cfg_initiator cfg_initiator_i (.i_clk_sys(clk_sys), .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd),
        .o_cfg_addr(cfg_addr), .o_be_n(be_n), .o_wdata(wdata), .i_rdata(rdata),
        .i_rvalid(rvalid));
    // short chip reset keeps the run brief
    diag_ctrl #(.CHIP_RST_CYCLES(4)) diag_ctrl_i (.i_clk_sys(clk_sys), .i_rstn(rstn),
        .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr),
        .i_primary_cmd_byte_enable_n(be_n), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
        .o_cfg_rvalid(rvalid), .i_mw_data_xfer(mw_xfer), .i_mw_queue_full(mw_full),
        .i_mw_addr(mw_addr), .i_cache_line_dw(cl_dw), .o_mw_disconnect(mw_disc),
        .i_ur_start(ur_start), .i_ur_cmd(ur_cmd), .i_ur_be_n(ur_be_n), .o_ur_prefetch(ur_pre),
        .o_ur_single_dword(ur_single), .o_ur_disconnect_first(ur_disc),
        .o_ur_fwd_be_n(fwd_be_n), .i_insert_sense(sense), .i_sense_input_only(only),
        .i_cmd_io_en(io_c), .i_cmd_mem_en(mem_c), .i_cmd_master_en(mst_c), .o_io_en(io),
        .o_mem_en(mem), .o_master_en(mst), .o_refuse_io_mem(refuse),
        .i_bctl_sec_reset(bctl_sec), .o_bctl_sec_reset_set(bctl_set), .o_sec_rst_n(sec_rst_n),
        .o_sec_if_reset(sec_if), .o_chip_rst_active(chip_act), .o_cfg_regs_clear(cfg_clr),
        .o_cnt_byte_en(cnt_en));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic mw(input logic [9:0] a, input logic full, input logic [7:0] cl, input logic e);
        @(negedge clk_sys);
        mw_xfer = 1'b1;
        mw_addr = a;
        mw_full = full;
        cl_dw   = cl;
        @(negedge clk_sys);
        mw_xfer = 1'b0;
        mw_full = 1'b0;
        chk({31'h0, mw_disc}, {31'h0, e}, "write disconnect");
    endtask

    task automatic ur(input logic [3:0] cmd, input logic single);
        @(negedge clk_sys);
        ur_start = 1'b1;
        ur_cmd   = cmd;
        ur_be_n  = 4'h5;
        @(negedge clk_sys);
        ur_start = 1'b0;
        chk({25'h0, ur_pre, ur_single, ur_disc, fwd_be_n},
            single ? 32'h35 : 32'h40, "upstream read");
    endtask

    // the pin needs two sync flops plus the output register, so four cycles is enough
    task automatic ins(input logic live, input logic o, input logic p, input logic [2:0] en);
        cfg_initiator_i.wr(8'h40, 4'hE, live ? 32'h20 : 32'h0);
        {only, sense} = {o, p};
        {io_c, mem_c, mst_c} = en;
        repeat (4) @(negedge clk_sys);
        chk({28'h0, io, mem, mst, refuse}, (live && o && p) ? 32'h1 : {28'h0, en, 1'b0},
            "forwarding enables");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always #50 clk_sys = ~clk_sys;

    initial begin
        #(3000 * 100);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {clk_sys, rstn, mw_xfer, mw_full, ur_start, sense, only, bctl_sec} = '0;
        {io_c, mem_c, mst_c, mw_addr, cl_dw, ur_cmd, ur_be_n} = '0;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        for (int k = 0; k < 7; k++) begin
            cfg_initiator_i.wr(ROWS[k].addr, ROWS[k].be_w, ROWS[k].wdata);
            cfg_initiator_i.rd(ROWS[k].addr, ROWS[k].be_r, q);
            chk(q, ROWS[k].exp_rd, "readback");
            chk({29'h0, cnt_en}, {29'h0, ROWS[k].exp_cnt}, "counter select");
        end
        $display("register rows done");
        mw(10'h00F, 1'b0, 8'h10, 1'b0);
        mw(10'h3FF, 1'b0, 8'h10, 1'b1);
        mw(10'h005, 1'b1, 8'h10, 1'b1);
        cfg_initiator_i.wr(8'h40, 4'hE, 32'h00000002);
        mw(10'h00F, 1'b0, 8'h10, 1'b1);
        mw(10'h00E, 1'b0, 8'h10, 1'b0);
        mw(10'h3FF, 1'b0, 8'h00, 1'b1);
        $display("write disconnect done");
        for (int p = 0; p < 2; p++) begin
            cfg_initiator_i.wr(8'h40, 4'hE, (p == 1) ? 32'h10 : 32'h0);
            foreach (CMDS[c]) begin
                ur(CMDS[c], p == 1 && c == 0);
            end
        end
        $display("upstream read done");
        ins(1'b1, 1'b1, 1'b1, 3'h7);
        ins(1'b1, 1'b1, 1'b0, 3'h7);
        ins(1'b0, 1'b1, 1'b1, 3'h5);
        ins(1'b1, 1'b0, 1'b1, 3'h6);
        $display("live insertion done");
        cfg_initiator_i.wr(8'h40, 4'hD, 32'h00000100);
        chk({30'h0, chip_act, bctl_set}, 32'h3, "chip reset start");
        chk({30'h0, sec_rst_n, sec_if}, 32'h1, "secondary reset start");
        bctl_sec = 1'b1;
        cfg_initiator_i.rd(8'h40, 4'h0, q);
        chk(q, 32'h00000100, "chip reset busy read");
        for (int w = 0; w < 10 && chip_act !== 1'b0; w++) @(negedge clk_sys);
        chk({31'h0, cfg_clr}, 32'h1, "config clear pulse");
        cfg_initiator_i.rd(8'h40, 4'h0, q);
        chk(q, 32'h00000000, "chip reset done read");
        chk({31'h0, sec_rst_n}, 32'h0, "secondary reset held");
        bctl_sec = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({30'h0, sec_rst_n, sec_if}, 32'h2, "secondary reset released");
        $display("chip reset done");
        cfg_initiator_i.wr(8'h40, 4'h0, 32'h00000632);
        rstn = 1'b0;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        cfg_initiator_i.rd(8'h40, 4'h0, q);
        chk(q, 32'h00000000, "reset value");
        chk({29'h0, cnt_en}, 32'h7, "reset counter select");
        $display("mid-run reset done");
        end_of_test();
    end
endmodule // diag_ctrl_tb
